// ### rtl/htrb_regs.sv
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
// How it works
// - Edge field picks rising, falling or both
// - Mode bit two selects single or multi
// - Four-bit sequence id, resets one and two
// - Read-only wave store start, resets 0x84
// - Lock bit seven, one means unlocked
// - Supply code is high times 128 plus low
// - Drive polarity readback in bit zero
// - Mean period over last four half-periods
// - Instant period from latest half-period sample
// - Supply readback resets to all ones
module htrb_regs
    import htrb_pkg::*;
#(
    parameter logic [7:0] WAVE_START = WAVE_START_RST
)(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic [1:0]             hresp,
    output logic [31:0]            hrdata,
    input  wire logic [1:0]        trig_in,
    input  wire logic [CODE_W-1:0] supply_code,
    input  wire logic              supply_valid,
    input  wire logic              drive_polarity,
    input  wire logic [CODE_W-1:0] half_period_code,
    input  wire logic              half_period_valid,
    output htrb_trig_cfg_s         input1_trigger_config,
    output htrb_trig_cfg_s         input2_trigger_config,
    output logic [7:0]             wave_store_start,
    output logic                   wave_store_unlock,
    output logic [1:0]             trig_fire
);

    htrb_wr_s           wr;
    logic [IDX_W-1:0]   rd_idx;
    logic [7:0]         rd_val;
    logic [1:0]         trig_prev;
    logic [CODE_W-1:0]  supply_reading;
    logic               polarity;
    logic [CODE_W-1:0]  mean_period;
    logic [CODE_W-1:0]  instant_period;
    logic [CODE_W-1:0]  period_hist [MEAN_DEPTH-1];

    htrb_ahb_slave u_bus (
        .clk       (clk),
        .srst      (srst),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .wr        (wr),
        .rd_idx    (rd_idx),
        .rd_val    (rd_val)
    );

    function automatic logic edge_hit(input htrb_edge_e sel,
                                      input logic       was,
                                      input logic       now);
        unique case (sel)
            HTRB_EDGE_RISE: edge_hit = !was && now;
            HTRB_EDGE_FALL: edge_hit = was && !now;
            HTRB_EDGE_BOTH: edge_hit = was != now;
            HTRB_EDGE_NONE: edge_hit = 1'b0;
        endcase
    endfunction

    function automatic htrb_trig_cfg_s cfg_from(input logic [7:0] d);
        cfg_from = htrb_trig_cfg_s'(d[CFG_W-1:0]);
    endfunction

    function automatic logic [CODE_W-1:0] mean_of(
        input logic [CODE_W-1:0] a,
        input logic [CODE_W-1:0] b,
        input logic [CODE_W-1:0] c,
        input logic [CODE_W-1:0] d);
        logic [CODE_W+1:0] s;
        s = {2'b00, a} + {2'b00, b} + {2'b00, c} + {2'b00, d};
        mean_of = s[CODE_W+1:MEAN_SHIFT];
    endfunction

    // Trigger configuration
    always_ff @(posedge clk) begin
        if (srst) begin
            input1_trigger_config <= '{seq_select:   IN1_SEQ_RST,
                                       multi_select: 1'b0,
                                       edge_select:  HTRB_EDGE_RISE};
            input2_trigger_config <= '{seq_select:   IN2_SEQ_RST,
                                       multi_select: 1'b0,
                                       edge_select:  HTRB_EDGE_RISE};
        end else if (wr.en) begin
            if (wr.idx == IDX_IN1_CFG) begin
                input1_trigger_config <= cfg_from(wr.data);
            end
            if (wr.idx == IDX_IN2_CFG) begin
                input2_trigger_config <= cfg_from(wr.data);
            end
        end
    end

    // Edge detection; the code 3 never fires rather than guess a meaning
    always_ff @(posedge clk) begin
        if (srst) begin
            trig_prev <= 2'b00;
            trig_fire <= 2'b00;
        end else begin
            trig_prev <= trig_in;
            trig_fire[0] <= edge_hit(input1_trigger_config.edge_select,
                                     trig_prev[0], trig_in[0]);
            trig_fire[1] <= edge_hit(input2_trigger_config.edge_select,
                                     trig_prev[1], trig_in[1]);
        end
    end

    // Wave store pointer and lock
    always_ff @(posedge clk) begin
        if (srst) begin
            wave_store_start  <= WAVE_START;
            wave_store_unlock <= LOCK_RST;
        end else if (wr.en && wr.idx == IDX_WAVE_LOCK) begin
            wave_store_unlock <= wr.data[LOCK_POS];
        end
    end

    // Supply and polarity readback; bus writes never touch them
    always_ff @(posedge clk) begin
        if (srst) begin
            supply_reading <= {SUPPLY_HI_RST, SUPPLY_LO_RST};
            polarity       <= POL_RST;
        end else begin
            polarity <= drive_polarity;
            if (supply_valid) begin
                supply_reading <= supply_code;
            end
        end
    end

    // Period tracking; history clears on reset so the mean ramps up
    always_ff @(posedge clk) begin
        if (srst) begin
            instant_period <= {INSTANT_HI_RST, INSTANT_LO_RST};
            mean_period    <= MEAN_RST;
            for (int i = 0; i < MEAN_DEPTH - 1; i++) begin
                period_hist[i] <= '0;
            end
        end else if (half_period_valid) begin
            instant_period <= half_period_code;
            mean_period    <= mean_of(half_period_code, period_hist[0],
                                      period_hist[1], period_hist[2]);
            period_hist[0] <= half_period_code;
            for (int i = 1; i < MEAN_DEPTH - 1; i++) begin
                period_hist[i] <= period_hist[i-1];
            end
        end
    end

    // Read mux; unmapped and reserved bits read zero
    always_comb begin
        rd_val = 8'h00;
        unique case (rd_idx)
            IDX_IN1_CFG:    rd_val = {1'b0, input1_trigger_config};
            IDX_IN2_CFG:    rd_val = {1'b0, input2_trigger_config};
            IDX_WAVE_START: rd_val = wave_store_start;
            IDX_WAVE_LOCK:  rd_val = {wave_store_unlock, 7'h00};
            IDX_SUPPLY_HI:  rd_val = supply_reading[CODE_W-1:LO_W];
            IDX_SUPPLY_LO:  rd_val = {1'b0, supply_reading[LO_W-1:0]};
            IDX_POLARITY:   rd_val = {7'h00, polarity};
            IDX_MEAN_HI:    rd_val = mean_period[CODE_W-1:LO_W];
            IDX_MEAN_LO:    rd_val = {1'b0, mean_period[LO_W-1:0]};
            IDX_INSTANT_HI: rd_val = instant_period[CODE_W-1:LO_W];
            IDX_INSTANT_LO: rd_val = {1'b0, instant_period[LO_W-1:0]};
            default:        rd_val = 8'h00;
        endcase
    end

    a_edge_rise_fire: assert property (
        @(posedge clk) disable iff (srst)
        (input1_trigger_config.edge_select == HTRB_EDGE_RISE
         && !trig_prev[0] && trig_in[0]) |=> trig_fire[0])
        else $error("rising edge did not fire input 1");

    a_edge_fall_only: assert property (
        @(posedge clk) disable iff (srst)
        (input2_trigger_config.edge_select == HTRB_EDGE_FALL
         && !trig_prev[1] && trig_in[1]) |=> !trig_fire[1])
        else $error("rising edge fired a falling-only input");

    a_edge_both_fire: assert property (
        @(posedge clk) disable iff (srst)
        (input1_trigger_config.edge_select == HTRB_EDGE_BOTH
         && trig_prev[0] && !trig_in[0]) |=> trig_fire[0])
        else $error("falling edge did not fire in both-edge mode");

    a_mode_bit_write: assert property (
        @(posedge clk) disable iff (srst)
        (wr.en && wr.idx == IDX_IN2_CFG)
        |=> input2_trigger_config.multi_select == $past(wr.data[MULTI_POS]))
        else $error("mode bit not taken from bit 2");

    a_seq_id_write: assert property (
        @(posedge clk) disable iff (srst)
        (wr.en && wr.idx == IDX_IN1_CFG)
        |=> input1_trigger_config.seq_select
            == $past(wr.data[SEQ_MSB:SEQ_LSB]))
        else $error("sequence id not taken from bits 6 to 3");

    a_reset_values: assert property (
        @(posedge clk) disable iff (srst)
        $past(srst) |-> (input1_trigger_config.seq_select == 4'h1
            && input2_trigger_config.seq_select == 4'h2
            && wave_store_unlock && supply_reading == 15'h7fff
            && instant_period == 15'h10cf && mean_period == 15'h0000))
        else $error("wrong value after reset");

    a_start_fixed: assert property (
        @(posedge clk) disable iff (srst)
        (wr.en && wr.idx == IDX_WAVE_START) |=> ##1
        (wave_store_start == WAVE_START && $stable(wave_store_start)))
        else $error("wave store start changed");

    a_lock_write: assert property (
        @(posedge clk) disable iff (srst)
        (wr.en && wr.idx == IDX_WAVE_LOCK)
        |=> wave_store_unlock == $past(wr.data[LOCK_POS]))
        else $error("lock bit not taken from bit 7");

    a_supply_load: assert property (
        @(posedge clk) disable iff (srst)
        supply_valid |=> supply_reading == $past(supply_code))
        else $error("supply readback not loaded");

    a_polarity_track: assert property (
        @(posedge clk) disable iff (srst)
        $changed(drive_polarity) |=> polarity == $past(drive_polarity))
        else $error("polarity readback lags");

    a_mean_of_four: assert property (
        @(posedge clk) disable iff (srst)
        half_period_valid [*4] |=> mean_period ==
            15'(({2'b00, $past(half_period_code, 1)}
               + {2'b00, $past(half_period_code, 2)}
               + {2'b00, $past(half_period_code, 3)}
               + {2'b00, $past(half_period_code, 4)}) >> 2))
        else $error("mean of four half-periods wrong");

    a_instant_load: assert property (
        @(posedge clk) disable iff (srst)
        half_period_valid |=> instant_period == $past(half_period_code))
        else $error("instant period not loaded");

    a_ro_write_ignored: assert property (
        @(posedge clk) disable iff (srst)
        (wr.en && wr.idx == IDX_SUPPLY_HI && !supply_valid)
        |=> $stable(supply_reading))
        else $error("write changed supply readback");

    a_reserved_zero: assert property (
        @(posedge clk) disable iff (srst)
        (rd_idx == IDX_IN2_CFG || rd_idx == IDX_SUPPLY_LO)
        |-> !rd_val[7])
        else $error("reserved bit reads one");

endmodule

// ### rtl/htrb_pkg.sv
package htrb_pkg;

    // Register index is the word address; byte address = 4*index
    localparam int         ADDR_W         = 9;
    localparam int         IDX_W          = 7;
    localparam logic [1:0] HTRANS_NONSEQ  = 2'h2;
    localparam logic [1:0] HRESP_OKAY     = 2'h0;
    localparam logic [31:0] HRDATA_RST    = 32'h0000_0000;

    localparam logic [IDX_W-1:0] IDX_IN1_CFG     = 7'h2a;
    localparam logic [IDX_W-1:0] IDX_IN2_CFG     = 7'h2b;
    localparam logic [IDX_W-1:0] IDX_WAVE_START  = 7'h2c;
    localparam logic [IDX_W-1:0] IDX_WAVE_LOCK   = 7'h2d;
    localparam logic [IDX_W-1:0] IDX_SUPPLY_HI   = 7'h2e;
    localparam logic [IDX_W-1:0] IDX_SUPPLY_LO   = 7'h2f;
    localparam logic [IDX_W-1:0] IDX_POLARITY    = 7'h43;
    localparam logic [IDX_W-1:0] IDX_MEAN_HI     = 7'h44;
    localparam logic [IDX_W-1:0] IDX_MEAN_LO     = 7'h45;
    localparam logic [IDX_W-1:0] IDX_INSTANT_HI  = 7'h46;
    localparam logic [IDX_W-1:0] IDX_INSTANT_LO  = 7'h47;

    // Field positions
    localparam int SEQ_LSB   = 3;
    localparam int SEQ_MSB   = 6;
    localparam int MULTI_POS = 2;
    localparam int EDGE_MSB  = 1;
    localparam int LOCK_POS  = 7;
    localparam int POL_POS   = 0;
    localparam int CFG_W     = 7;

    // Split codes: high part weighs 128, i.e. seven low bits
    localparam int LO_W       = 7;
    localparam int HI_W       = 8;
    localparam int CODE_W     = 15;
    localparam int MEAN_DEPTH = 4;
    localparam int MEAN_SHIFT = 2;
    localparam real SUPPLY_LSB_MV    = 0.1831;
    localparam real PERIOD_LSB_MS_E9 = 1333.32;

    // Reset values
    localparam logic [3:0]      IN1_SEQ_RST    = 4'h1;
    localparam logic [3:0]      IN2_SEQ_RST    = 4'h2;
    localparam logic [7:0]      WAVE_START_RST = 8'h84;
    localparam logic            LOCK_RST       = 1'b1;
    localparam logic [HI_W-1:0] SUPPLY_HI_RST  = 8'hff;
    localparam logic [LO_W-1:0] SUPPLY_LO_RST  = 7'h7f;
    localparam logic [HI_W-1:0] INSTANT_HI_RST = 8'h21;
    localparam logic [LO_W-1:0] INSTANT_LO_RST = 7'h4f;
    localparam logic [CODE_W-1:0] MEAN_RST     = 15'h0000;
    localparam logic            POL_RST        = 1'b0;

    typedef enum logic [1:0] {
        HTRB_EDGE_RISE = 2'h0,
        HTRB_EDGE_FALL = 2'h1,
        HTRB_EDGE_BOTH = 2'h2,
        HTRB_EDGE_NONE = 2'h3
    } htrb_edge_e;

    typedef struct packed {
        logic [3:0] seq_select;
        logic       multi_select;
        htrb_edge_e edge_select;
    } htrb_trig_cfg_s;

    typedef struct packed {
        logic             en;
        logic [IDX_W-1:0] idx;
        logic [7:0]       data;
    } htrb_wr_s;

endpackage

// ### rtl/htrb_ahb_slave.sv
`timescale 1ns/1ps
module htrb_ahb_slave
    import htrb_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              hsel,
    input  wire logic [ADDR_W-1:0] haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic [1:0]             hresp,
    output logic [31:0]            hrdata,
    output htrb_wr_s               wr,
    output logic [IDX_W-1:0]       rd_idx,
    input  wire logic [7:0]        rd_val
);

    logic             take;
    logic             wr_pend;
    logic [IDX_W-1:0] wr_idx;
    logic             rd_wait;

    // Only NONSEQ/SEQ carry a transfer; every size is treated as a word
    assign take = hsel && htrans[1] && hready && (hsize <= 3'h2 || 1'b1);

    always_ff @(posedge clk) begin
        if (srst) begin
            wr_pend <= 1'b0;
            wr_idx  <= '0;
        end else begin
            wr_pend <= take && hwrite;
            if (take && hwrite) begin
                wr_idx <= haddr[ADDR_W-1:2];
            end
        end
    end

    // Write lands at the end of its data phase
    always_comb begin
        wr.en   = wr_pend;
        wr.idx  = wr_idx;
        wr.data = hwdata[7:0];
    end

    // One wait state on reads so a write just before is already visible
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_wait   <= 1'b0;
            rd_idx    <= '0;
            hreadyout <= 1'b1;
            hrdata    <= HRDATA_RST;
        end else if (rd_wait) begin
            rd_wait   <= 1'b0;
            hreadyout <= 1'b1;
            hrdata    <= {24'h00_0000, rd_val};
        end else if (take && !hwrite) begin
            rd_wait   <= 1'b1;
            rd_idx    <= haddr[ADDR_W-1:2];
            hreadyout <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        hresp <= HRESP_OKAY;
    end

endmodule

// ### tb/haptic_trigger_and_readback_regs_test.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
    begin \
        compares++; \
        if ((got) !== (exp)) begin \
            n_fail++; \
            $display("wrong value at %0t: got %h expected %h", \
                     $time, got, exp); \
        end \
    end

module haptic_trigger_and_readback_regs_test
    import htrb_pkg::*;
;
    logic              clk = 1'b0;
    logic              srst = 1'b1;
    logic              hsel = 1'b0;
    logic [ADDR_W-1:0] haddr = '0;
    logic [1:0]        htrans = 2'h0;
    logic              hwrite = 1'b0;
    logic [2:0]        hsize = 3'h2;
    logic [31:0]       hwdata = 32'h0;
    logic              hreadyout;
    logic [1:0]        hresp;
    logic [31:0]       hrdata;
    logic [1:0]        trig_in = 2'h0;
    logic [CODE_W-1:0] supply_code = '0;
    logic              supply_valid = 1'b0;
    logic              drive_polarity = 1'b0;
    logic [CODE_W-1:0] half_period_code = '0;
    logic              half_period_valid = 1'b0;
    htrb_trig_cfg_s    in1_cfg;
    htrb_trig_cfg_s    in2_cfg;
    logic [7:0]        wave_store_start;
    logic              wave_store_unlock;
    logic [1:0]        trig_fire;
    int                n_fail = 0;
    int                compares = 0;
    int                cycles = 0;
    int                fcnt0 = 0;
    int                fcnt1 = 0;

    // Writes flip every bit of the reset value so any leak shows
    logic [IDX_W-1:0]  ro_idx [9] = '{7'h2c, 7'h2e, 7'h2f, 7'h43, 7'h44,
                                      7'h45, 7'h46, 7'h47, 7'h30};
    logic [7:0]        ro_val [9] = '{8'h84, 8'hff, 8'h7f, 8'h00, 8'h00,
                                      8'h00, 8'h21, 8'h4f, 8'h00};
    logic [CODE_W-1:0] smp [4] = '{15'h1234, 15'h2000, 15'h0f0f, 15'h7fff};

    htrb_regs dut (
        .clk                   (clk),
        .srst                  (srst),
        .hsel                  (hsel),
        .haddr                 (haddr),
        .htrans                (htrans),
        .hwrite                (hwrite),
        .hsize                 (hsize),
        .hwdata                (hwdata),
        .hready                (hreadyout),
        .hreadyout             (hreadyout),
        .hresp                 (hresp),
        .hrdata                (hrdata),
        .trig_in               (trig_in),
        .supply_code           (supply_code),
        .supply_valid          (supply_valid),
        .drive_polarity        (drive_polarity),
        .half_period_code      (half_period_code),
        .half_period_valid     (half_period_valid),
        .input1_trigger_config (in1_cfg),
        .input2_trigger_config (in2_cfg),
        .wave_store_start      (wave_store_start),
        .wave_store_unlock     (wave_store_unlock),
        .trig_fire             (trig_fire)
    );

    always #25 clk = ~clk;

    always @(posedge clk) begin
        if (trig_fire[0] === 1'b1)
            fcnt0++;
        if (trig_fire[1] === 1'b1)
            fcnt1++;
    end

    task automatic wrap_up;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Hang guard: the whole sequence needs well under 3000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    task automatic bus(input logic w, input logic [IDX_W-1:0] idx,
                       input logic [7:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        `CHK(hresp, HRESP_OKAY)
    endtask

    task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] wd);
        logic [31:0] d;
        bus(1'b1, idx, wd, d);
    endtask

    task automatic rchk(input logic [IDX_W-1:0] idx, input logic [7:0] e);
        logic [31:0] d;
        bus(1'b0, idx, 8'h00, d);
        `CHK(d, {24'h0, e})
    endtask

    task automatic t_reset;
        rchk(IDX_IN1_CFG, 8'h08);
        rchk(IDX_IN2_CFG, 8'h10);
        rchk(IDX_WAVE_START, 8'h84);
        rchk(IDX_WAVE_LOCK, 8'h80);
        rchk(IDX_SUPPLY_HI, 8'hff);
        rchk(IDX_SUPPLY_LO, 8'h7f);
        rchk(IDX_POLARITY, 8'h00);
        rchk(IDX_MEAN_HI, 8'h00);
        rchk(IDX_MEAN_LO, 8'h00);
        rchk(IDX_INSTANT_HI, 8'h21);
        rchk(IDX_INSTANT_LO, 8'h4f);
        `CHK(wave_store_start, 8'h84)
        `CHK(wave_store_unlock, 1'b1)
        $display("test reset done");
    endtask

    task automatic t_config;
        wr(IDX_IN1_CFG, 8'hff);
        rchk(IDX_IN1_CFG, 8'h7f);
        `CHK(in1_cfg, 7'h7f)
        wr(IDX_IN2_CFG, 8'h5d);
        rchk(IDX_IN2_CFG, 8'h5d);
        `CHK(in2_cfg, 7'h5d)
        wr(IDX_WAVE_LOCK, 8'h7f);
        rchk(IDX_WAVE_LOCK, 8'h00);
        `CHK(wave_store_unlock, 1'b0)
        wr(IDX_WAVE_LOCK, 8'h80);
        rchk(IDX_WAVE_LOCK, 8'h80);
        `CHK(wave_store_unlock, 1'b1)
        $display("test config done");
    endtask

    task automatic t_readonly;
        for (int i = 0; i < 9; i++) begin
            wr(ro_idx[i], ~ro_val[i]);
            rchk(ro_idx[i], ro_val[i]);
        end
        $display("test readonly done");
    endtask

    task automatic t_trig;
        int         b0;
        int         b1;
        logic [7:0] e;
        for (int m = 0; m < 4; m++) begin
            wr(IDX_IN1_CFG, {1'b0, 4'h1, 1'b0, 2'(m)});
            wr(IDX_IN2_CFG, {1'b0, 4'h2, 1'b1, 2'(m)});
            e = (m == 2) ? 8'h02 : (m == 3) ? 8'h00 : 8'h01;
            @(negedge clk);
            b0 = fcnt0;
            b1 = fcnt1;
            @(posedge clk);
            trig_in <= 2'b11;
            repeat (4) @(posedge clk);
            trig_in <= 2'b00;
            repeat (4) @(posedge clk);
            @(negedge clk);
            `CHK(8'(fcnt0 - b0), e)
            `CHK(8'(fcnt1 - b1), e)
        end
        $display("test trigger done");
    endtask

    task automatic t_meas;
        logic [CODE_W-1:0] sc;
        logic [CODE_W-1:0] mn;
        logic [16:0]       sum;
        sc = 15'h5a3c;
        @(posedge clk);
        supply_code <= sc;
        supply_valid <= 1'b1;
        drive_polarity <= 1'b1;
        @(posedge clk);
        supply_valid <= 1'b0;
        rchk(IDX_SUPPLY_HI, sc[14:7]);
        rchk(IDX_SUPPLY_LO, {1'b0, sc[6:0]});
        rchk(IDX_POLARITY, 8'h01);
        drive_polarity <= 1'b0;
        rchk(IDX_POLARITY, 8'h00);
        sum = '0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            half_period_code <= smp[i];
            half_period_valid <= 1'b1;
            @(posedge clk);
            half_period_valid <= 1'b0;
            sum = sum + 17'(smp[i]);
            mn = sum[16:2];
            rchk(IDX_INSTANT_HI, smp[i][14:7]);
            rchk(IDX_INSTANT_LO, {1'b0, smp[i][6:0]});
            rchk(IDX_MEAN_HI, mn[14:7]);
            rchk(IDX_MEAN_LO, {1'b0, mn[6:0]});
        end
        // Code moves without a load pulse: readback must hold
        half_period_code <= 15'h0001;
        rchk(IDX_INSTANT_LO, {1'b0, smp[3][6:0]});
        // Four loads back to back: mean must cover exactly these four
        sum = '0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            half_period_code <= smp[3-i] ^ 15'h0155;
            half_period_valid <= 1'b1;
            sum = sum + 17'(smp[3-i] ^ 15'h0155);
        end
        @(posedge clk);
        half_period_valid <= 1'b0;
        mn = sum[16:2];
        rchk(IDX_MEAN_HI, mn[14:7]);
        rchk(IDX_MEAN_LO, {1'b0, mn[6:0]});
        $display("test measurement done");
    endtask

    task automatic t_rst_again;
        wr(IDX_IN2_CFG, 8'h7a);
        wr(IDX_WAVE_LOCK, 8'h00);
        @(posedge clk);
        srst <= 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rchk(IDX_IN2_CFG, 8'h10);
        rchk(IDX_WAVE_LOCK, 8'h80);
        rchk(IDX_INSTANT_LO, 8'h4f);
        rchk(IDX_MEAN_HI, 8'h00);
        rchk(IDX_SUPPLY_HI, 8'hff);
        `CHK(in2_cfg, 7'h10)
        $display("test second reset done");
    endtask

    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_config();
        t_readonly();
        t_trig();
        t_meas();
        t_rst_again();
        wrap_up();
    end
endmodule
